// [radio_command_property_engine_test.sv]
`timescale 1ns/100ps
`include "rcpe_map.svh"
module radio_command_property_engine_test;
  logic clk;
  logic reset_n;
  logic sclkPin, serialEnable_n, sdioIn, sdioOut, sdioOe, irqOnTwo, groupValid, ok;
  logic [2:0] driveEn;
  logic [2:0] driveLvl;
  logic [1:0] threeFn;
  logic [7:0] rssi;
  logic [7:0] snr;
  logic [63:0] group;
  logic o1, o1e, o2, o2e, o3, o3e, anaEn, digEn, xtalEn, bitClk;
  logic [15:0] freq, deemph, stereo, mono, smute, vol, mute, dscfg;
  logic [127:0] resp;
  int errors;
  int compares;

  // 10 MHz device clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  rcpe_core #(.PART_CODE(8'h3c)) dut ( // Arbitrary part code
    .clk(clk), .reset_n(reset_n), .sclkPin(sclkPin), .serialEnable_n(serialEnable_n), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .outputDriveEnable(driveEn), .outputDriveLevel(driveLvl),
    .irqOnOutputTwo(irqOnTwo), .outputThreeFunction(threeFn), .audioBitClock(bitClk), .rssiLevel(rssi),
    .snrLevel(snr), .groupValid(groupValid), .groupData(group), .generalOutputOne(o1),
    .generalOutputOneOe(o1e), .generalOutputTwoIrq(o2), .generalOutputTwoIrqOe(o2e),
    .generalOutputThree(o3), .generalOutputThreeOe(o3e), .analogEnable(anaEn),
    .digitalAudioEnable(digEn), .crystalEnable(xtalEn), .tunedFrequency(freq), .deemphasisSelect(deemph),
    .stereoBlendLevel(stereo), .monoBlendLevel(mono), .softMuteCeiling(smute), .volumeLevel(vol),
    .muteControl(mute), .dataServiceSetup(dscfg));

  rcpe_host_model host (.clk(clk), .sclkPin(sclkPin), .serialEnable_n(serialEnable_n), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe));

  task automatic summarize();
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] rb(input int k);
    rb = resp[127 - 8 * k -: 8];
  endfunction : rb

  // One command; a lost clear-to-send ends the run
  task automatic x(input logic [63:0] d);
    host.cmd(d, resp, ok);
    chk({15'h0, ok}, 16'h0001);
    if (ok !== 1'b1)
      summarize();
  endtask : x

  task automatic t_reset();
    host.frame(`K_RD1, 64'h0, 0, 8, resp);
    chk({8'h0, resp[7:0]}, 16'h0080);
    chk({15'h0, anaEn}, 16'h0000);
    chk(deemph, 16'h0002);
    chk(stereo, 16'h0031);
    chk(mono, 16'h001e);
    chk(smute, 16'h0010);
    chk(vol, 16'h003f);
    chk(mute, 16'h0000);
    chk(dscfg, 16'h0000);
  endtask : t_reset

  task automatic t_gpo();
    logic [2:0] l;
    for (int i = 0; i < 8; i++)
    begin
      l = {i[0], i[2], i[1]};
      driveEn = i[2:0];
      driveLvl = l;
      repeat (2) @(negedge clk);
      chk({10'h0, o3e, o2e, o1e, o3 & o3e, o2 & o2e, o1 & o1e}, {10'h0, i[2:0], i[2:0] & l});
    end
    // Special functions: interrupt pin, crystal releases pin three
    irqOnTwo = 1'b1;
    threeFn = 2'h1;
    repeat (2) @(negedge clk);
    chk({13'h0, o2e, o2, o3e}, 16'h0006);
    threeFn = 2'h0;
  endtask : t_gpo

  task automatic t_power();
    x({`C_TUNE, 56'h0});
    chk({8'h0, rb(0) & 8'h40}, 16'h0040);
    x({`C_PWRUP, 8'h10, 8'h01, 40'h0});
    chk({13'h0, anaEn, digEn, xtalEn}, 16'h0007);
    // Bit clock on pin three in digital mode, one cycle late
    threeFn = 2'h2;
    repeat (2) @(negedge clk);
    chk({14'h0, o3e, o3}, 16'h0002);
    bitClk = 1'b1;
    @(negedge clk);
    chk({14'h0, o3e, o3}, 16'h0003);
    threeFn = 2'h0;
    x({`C_REV, 56'h0});
    chk({8'h0, rb(1)}, 16'h003c);
  endtask : t_power

  task automatic t_props();
    logic [15:0] num [15] = '{16'h1100, 16'h1105, 16'h1106, 16'h1200, 16'h1302, 16'h1400, 16'h1401,
      16'h1402, 16'h1403, 16'h1404, 16'h1500, 16'h1501, 16'h1502, 16'h4000, 16'h4001};
    logic [15:0] def [15] = '{16'h0002, 16'h0031, 16'h001e, 16'h0000, 16'h0010, 16'h222e, 16'h2a26,
      16'h000a, 16'h0003, 16'h0014, 16'h0000, 16'h0000, 16'h0000, 16'h003f, 16'h0000};
    for (int i = 0; i < 15; i++)
    begin
      x({`C_GETP, 8'h0, num[i], 32'h0});
      chk({rb(2), rb(3)}, def[i]);
    end
    x({`C_SETP, 8'h0, 16'h4000, 16'h0011, 16'h0});
    chk(vol, 16'h0011);
    // Aborted write must leave the volume alone
    host.poll(ok);
    chk({15'h0, ok}, 16'h0001);
    host.frame(`K_WR, {`C_SETP, 8'h0, 16'h4000, 16'h0022, 16'h0}, 40, 0, resp);
    host.poll(ok);
    chk({15'h0, ok}, 16'h0001);
    chk(vol, 16'h0011);
    x({`C_SETP, 8'h0, 16'h4001, 16'h0002, 16'h0});
    chk(mute, 16'h0002);
  endtask : t_props

  // Strength at and one below the validity threshold
  task automatic t_tune();
    for (int i = 0; i < 2; i++)
    begin
      rssi = 8'h14 - 8'(i);
      snr = 8'h03;
      x({`C_TUNE, 8'h0, 16'h2710, 32'h0});
      chk({freq[15:1], resp[120]}, 16'h2711);
      x({`C_TSTAT, 8'h01, 48'h0});
      chk({rb(2), rb(3)}, 16'h2710);
      chk({8'h0, rb(1) & 8'h01}, 16'(1 - i));
    end
  endtask : t_tune

  task automatic t_seek();
    rssi = 8'h14;
    x({`C_SEEK, 8'h08, 48'h0});
    chk(freq, 16'h271a);
    rssi = 8'h00;
    x({`C_SEEK, 8'h08, 48'h0});
    x({`C_TSTAT, 8'h01, 48'h0});
    chk({8'h0, rb(1) & 8'h81}, 16'h0080);
    chk({rb(2), rb(3)}, 16'h2a26);
  endtask : t_seek

  task automatic push(input logic [63:0] g);
    group = g;
    groupValid = 1'b1;
    @(negedge clk);
    groupValid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : push

  task automatic t_data();
    x({`C_SETP, 8'h0, 16'h1501, 16'h0002, 16'h0});
    x({`C_SETP, 8'h0, 16'h1500, 16'h0001, 16'h0});
    push(64'h0123456789abcdef);
    chk({15'h0, o2}, 16'h0001);
    push(64'hfedcba9876543210);
    chk({15'h0, o2}, 16'h0000);
    x({`C_DSTAT, 56'h0});
    chk({rb(3), 7'h0, resp[112]}, 16'h0201);
    chk(resp[95:80], 16'h0123);
    chk(resp[47:32], 16'hcdef);
    // Zero strength sits below the mono level
    x({`C_QSTAT, 56'h0});
    chk({rb(1), rb(4)}, 16'h0100);
  endtask : t_data

  task automatic t_down();
    x({`C_PWRDN, 56'h0});
    chk({15'h0, anaEn}, 16'h0000);
    x({`C_PWRUP, 8'h00, 8'h00, 40'h0});
    chk({14'h0, anaEn, digEn}, 16'h0002);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({vol[14:0], anaEn}, 16'h007e);
  endtask : t_down

  // Main sequence
  initial
  begin
    errors = 0;
    compares = 0;
    reset_n = 1'b0;
    driveEn = 3'h0;
    driveLvl = 3'h0;
    irqOnTwo = 1'b0;
    threeFn = 2'h0;
    bitClk = 1'b0;
    rssi = 8'h0;
    snr = 8'h0;
    groupValid = 1'b0;
    group = 64'h0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_gpo();
    t_power();
    t_props();
    t_tune();
    t_seek();
    t_data();
    t_down();
    summarize();
  end
endmodule : radio_command_property_engine_test

// [rcpe_core.sv]
`timescale 1ns/100ps
`include "rcpe_map.svh"

// Summary of operation
// - Each general output drives low, high or floats.
// - Output two can carry interrupts; output three crystal or bit clock.
// - Reset low clears everything to defaults and holds the serial port idle.
// - Reset high resumes operation with default settings.
// - Powerdown stops radio logic but the serial port still takes commands.
// - A command byte plus arguments is written, then executed.
// - Every response starts with a status byte: interrupts and clear-to-send.
// - Code 01 powers up and picks audio output and clock source.
// - Code 10 returns revision; code 11 powers down.
// - Code 12 writes a property; code 13 reads one back.
// - Codes 20, 21, 22: tune, seek, report tune or seek status.
// - Codes 23, 24: signal quality and data-service status with FIFO pop.
// - Property 1100 selects de-emphasis, default 2.
// - Property 1105 is the stereo blend level, default 31 hex.
// - Property 1106 is the mono blend level, default 1e hex.
// - Property 1302 is soft-mute ceiling, default 16 dB, zero disables.
// - Properties 1400 and 1401 bound the seek band.
// - Property 1402 is the seek step, default 0a hex.
// - Valid channel needs SNR and strength at or above their thresholds.
// - Data received flag only once FIFO count reaches property 1501.
// - Property 4000 sets volume; 4001 mutes left and right separately.
// - Properties 1200 and 1500 choose interrupt sources, none by default.
// - A command write is eight bytes: code then seven arguments.
// - A response read is one or sixteen bytes, status first.
module rcpe_core
  import rcpe_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int EXEC_CYCLES = 4,
  parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] FW_CODE = 8'h11 // Arbitrary value
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclkPin,
  input wire logic serialEnable_n,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  input wire logic [2:0] outputDriveEnable,
  input wire logic [2:0] outputDriveLevel,
  input wire logic irqOnOutputTwo,
  input wire logic [1:0] outputThreeFunction,
  input wire logic audioBitClock,
  input wire logic [7:0] rssiLevel,
  input wire logic [7:0] snrLevel,
  input wire logic groupValid,
  input wire logic [63:0] groupData,
  output logic generalOutputOne,
  output logic generalOutputOneOe,
  output logic generalOutputTwoIrq,
  output logic generalOutputTwoIrqOe,
  output logic generalOutputThree,
  output logic generalOutputThreeOe,
  output logic analogEnable,
  output logic digitalAudioEnable,
  output logic crystalEnable,
  output logic [15:0] tunedFrequency,
  output logic [15:0] deemphasisSelect,
  output logic [15:0] stereoBlendLevel,
  output logic [15:0] monoBlendLevel,
  output logic [15:0] softMuteCeiling,
  output logic [15:0] volumeLevel,
  output logic [15:0] muteControl,
  output logic [15:0] dataServiceSetup
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed {
    logic [1:0] sclkS;
    logic [1:0] senS;
    logic [1:0] sdioS;
    logic sclkP;
    rcpe_ser_t ser;
    logic [7:0] bits;
    logic [6:0] ctlSh;
    logic [63:0] cmd;
    logic [127:0] rdSh;
    logic rdLong;
    logic rdPin;
    logic sdOut;
    logic sdOe;
    logic g1Rd;
    rcpe_exec_t ex;
    logic [7:0] exCnt;
    logic cts;
    logic err;
    logic stc;
    logic qInt;
    logic valid;
    logic limit;
    logic pwr;
    logic dig;
    logic xtal;
    logic seekUp;
    logic seekWrap;
    logic seekEval;
    logic tuneOnly;
    logic [15:0] freq;
    logic [15:0] seekStart;
    logic [119:0] resp;
    logic [14:0][15:0] props;
    logic [FIFO_DEPTH-1:0][63:0] fifo;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic g1;
    logic g1Oe;
    logic g2;
    logic g2Oe;
    logic g3;
    logic g3Oe;
  } rcpe_state_t;

  rcpe_state_t q;
  rcpe_state_t d;

  // Property number to table slot
  function automatic logic [3:0] propIdx(input logic [15:0] p);
    case (p)
      `P_DEEMPH: return `I_DEEMPH;
      `P_STEREO: return `I_STEREO;
      `P_MONO: return `I_MONO;
      `P_QSEL: return `I_QSEL;
      `P_SMUTE: return `I_SMUTE;
      `P_LOWER: return `I_LOWER;
      `P_UPPER: return `I_UPPER;
      `P_STEP: return `I_STEP;
      `P_SNR: return `I_SNR;
      `P_RSSI: return `I_RSSI;
      `P_DSSEL: return `I_DSSEL;
      `P_DSTHR: return `I_DSTHR;
      `P_DSCFG: return `I_DSCFG;
      `P_VOL: return `I_VOL;
      `P_MUTE: return `I_MUTE;
      default: return `I_NONE;
    endcase
  endfunction : propIdx

  // Default value of each slot
  function automatic logic [15:0] propDef(input logic [3:0] i);
    case (i)
      `I_DEEMPH: return `D_DEEMPH;
      `I_STEREO: return `D_STEREO;
      `I_MONO: return `D_MONO;
      `I_QSEL: return `D_QSEL;
      `I_SMUTE: return `D_SMUTE;
      `I_LOWER: return `D_LOWER;
      `I_UPPER: return `D_UPPER;
      `I_STEP: return `D_STEP;
      `I_SNR: return `D_SNR;
      `I_RSSI: return `D_RSSI;
      `I_DSSEL: return `D_DSSEL;
      `I_DSTHR: return `D_DSTHR;
      `I_DSCFG: return `D_DSCFG;
      `I_VOL: return `D_VOL;
      `I_MUTE: return `D_MUTE;
      default: return 16'h0000;
    endcase
  endfunction : propDef

  // Whole next-state computation
  always_comb
  begin
    logic rise;
    logic fall;
    logic sdi;
    logic senHi;
    logic pop;
    logic push;
    logic okNow;
    logic groupsReady;
    logic dsIrq;
    logic lo;
    logic hi;
    logic fin;
    logic [7:0] ctl;
    logic [7:0] c;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    logic [7:0] a4;
    logic [7:0] a5;
    logic [7:0] st;
    logic [3:0] pi;
    logic [15:0] nf;
    d = q;
    // Pins pass two flops before anything looks at them
    d.sclkS = {q.sclkS[0], sclkPin};
    d.senS = {q.senS[0], serialEnable_n};
    d.sdioS = {q.sdioS[0], sdioIn};
    d.sclkP = q.sclkS[1];
    rise = q.sclkS[1] & ~q.sclkP;
    fall = ~q.sclkS[1] & q.sclkP;
    senHi = q.senS[1];
    sdi = q.sdioS[1];
    ctl = {q.ctlSh, sdi};
    c = q.cmd[63:56];
    a1 = q.cmd[55:48];
    a2 = q.cmd[47:40];
    a3 = q.cmd[39:32];
    a4 = q.cmd[31:24];
    a5 = q.cmd[23:16];
    pi = propIdx({a2, a3});
    okNow = ({8'h00, rssiLevel} >= q.props[`I_RSSI]) && ({8'h00, snrLevel} >= q.props[`I_SNR]);
    groupsReady = (q.cnt != '0) && (16'(q.cnt) >= q.props[`I_DSTHR]);
    dsIrq = groupsReady & q.props[`I_DSSEL][0];
    lo = {8'h00, rssiLevel} < q.props[`I_MONO];
    hi = {8'h00, rssiLevel} >= q.props[`I_STEREO];
    st = {q.cts, q.err, 2'b00, q.qInt, dsIrq, 1'b0, q.stc};
    push = groupValid && q.pwr && (q.cnt != CW'(FIFO_DEPTH));
    pop = 1'b0;
    fin = 1'b0;
    nf = q.freq;

    // Command execution
    unique case (q.ex)
      EX_IDLE: ;
      EX_RUN:
      begin
        d.exCnt = q.exCnt + 8'h01;
        if (q.exCnt == 8'(EXEC_CYCLES - 1))
        begin
          d.ex = EX_IDLE;
          d.cts = 1'b1;
          d.err = 1'b0;
          d.resp = '0;
          if (!q.pwr && c != `C_PWRUP)
            d.err = 1'b1;
          else
          begin
            case (c)
              `C_PWRUP:
              begin
                d.pwr = 1'b1;
                d.xtal = a1[`A_XTAL];
                d.dig = a2[`A_DIG];
              end
              `C_REV: d.resp = {PART_CODE, FW_CODE, 104'h0};
              `C_PWRDN:
              begin
                d.pwr = 1'b0;
                d.dig = 1'b0;
                d.xtal = 1'b0;
              end
              `C_SETP:
                if (pi == `I_NONE)
                  d.err = 1'b1;
                else
                  d.props[pi] = {a4, a5};
              `C_GETP:
                if (pi == `I_NONE)
                  d.err = 1'b1;
                else
                  d.resp = {8'h00, q.props[pi], 96'h0};
              `C_TUNE, `C_SEEK:
              begin
                // Completion is signalled by the seek engine
                d.ex = EX_SEEK;
                d.cts = 1'b0;
                d.tuneOnly = (c == `C_TUNE);
                d.seekEval = (c == `C_TUNE);
                d.freq = (c == `C_TUNE) ? {a2, a3} : q.freq;
                d.seekStart = q.freq;
                d.seekUp = a1[`A_UP];
                d.seekWrap = a1[`A_WRAP];
              end
              `C_TSTAT:
              begin
                if (a1[`A_ACK])
                  d.stc = 1'b0;
                d.resp = {q.limit, 6'h00, q.valid, q.freq, rssiLevel, snrLevel, 80'h0};
              end
              `C_QSTAT:
              begin
                if (a1[`A_ACK])
                  d.qInt = 1'b0;
                d.resp = {6'h00, hi, lo, 8'h00, {hi, 7'h00}, rssiLevel, snrLevel, 80'h0};
              end
              `C_DSTAT:
              begin
                pop = (q.cnt != '0);
                d.resp = {7'h00, groupsReady, 8'h00, 8'(q.cnt), pop ? q.fifo[q.rp] : 64'h0, 32'h0};
              end
              default: d.err = 1'b1;
            endcase
          end
        end
      end
      EX_SEEK:
      begin
        // Alternate a step cycle with an evaluate cycle
        if (q.seekEval)
        begin
          if (okNow || q.tuneOnly)
          begin
            fin = 1'b1;
            d.valid = okNow;
            d.limit = 1'b0;
          end
          else
            d.seekEval = 1'b0;
        end
        else
        begin
          nf = q.seekUp ? q.freq + q.props[`I_STEP] : q.freq - q.props[`I_STEP];
          if (q.seekUp ? nf > q.props[`I_UPPER] : nf < q.props[`I_LOWER])
            nf = q.seekUp ? q.props[`I_LOWER] : q.props[`I_UPPER];
          if ((q.freq == (q.seekUp ? q.props[`I_UPPER] : q.props[`I_LOWER]) && !q.seekWrap)
              || nf == q.seekStart)
          begin
            // Band edge without wrap, or full circle: give up
            fin = 1'b1;
            d.valid = 1'b0;
            d.limit = 1'b1;
          end
          else
          begin
            d.freq = nf;
            d.seekEval = 1'b1;
          end
        end
        if (fin)
        begin
          d.ex = EX_IDLE;
          d.cts = 1'b1;
          d.stc = 1'b1;
        end
      end
      default: d.ex = EX_IDLE;
    endcase

    // Quality interrupt set after the ack, so a new event wins
    if (q.pwr && ((q.props[`I_QSEL][0] & lo) | (q.props[`I_QSEL][1] & hi)))
      d.qInt = 1'b1;

    // Data-service FIFO; overflow drops the new group
    if (push)
    begin
      d.fifo[q.wp] = groupData;
      d.wp = q.wp + PW'(1);
    end
    if (pop)
      d.rp = q.rp + PW'(1);
    d.cnt = q.cnt + CW'(push) - CW'(pop);

    // Serial port framing
    if (senHi)
    begin
      // Only a complete eight-byte write is executed; aborts are dropped
      if (q.ser == SER_WRITE && q.bits == `W_BITS && q.ex == EX_IDLE)
      begin
        d.ex = EX_RUN;
        d.exCnt = '0;
        d.cts = 1'b0;
      end
      d.ser = SER_IDLE;
      d.sdOe = 1'b0;
      d.g1Rd = 1'b0;
    end
    else
    begin
      unique case (q.ser)
        SER_IDLE:
        begin
          d.ser = SER_CTRL;
          d.bits = '0;
        end
        SER_CTRL:
          if (rise)
          begin
            d.ctlSh = ctl[6:0];
            d.bits = q.bits + 8'h01;
            if (q.bits == 8'h07)
            begin
              d.bits = '0;
              d.rdSh = {st, q.resp};
              d.rdLong = ctl[6];
              d.rdPin = ctl[5];
              case (ctl)
                `K_WR: d.ser = (q.cts && q.ex == EX_IDLE) ? SER_WRITE : SER_HOLD;
                `K_RD1, `K_RD16, `K_RD1G, `K_RD16G: d.ser = SER_READ;
                default: d.ser = SER_HOLD;
              endcase
            end
          end
        SER_WRITE:
          if (rise && q.bits != `W_BITS)
          begin
            d.cmd = {q.cmd[62:0], sdi};
            d.bits = q.bits + 8'h01;
          end
        SER_READ:
          if (fall)
          begin
            if (q.bits != (q.rdLong ? `R_BITS16 : `R_BITS1))
            begin
              d.sdOut = q.rdSh[127];
              d.rdSh = {q.rdSh[126:0], 1'b0};
              d.bits = q.bits + 8'h01;
              d.sdOe = ~q.rdPin;
              d.g1Rd = q.rdPin;
            end
            else
            begin
              d.sdOe = 1'b0;
              d.g1Rd = 1'b0;
            end
          end
        SER_HOLD: ;
        default: d.ser = SER_IDLE;
      endcase
    end

    // General outputs, registered so the pins never glitch
    d.g1 = d.g1Rd ? d.sdOut : outputDriveLevel[0];
    d.g1Oe = d.g1Rd | outputDriveEnable[0];
    if (irqOnOutputTwo)
    begin
      d.g2 = ~(q.stc | q.qInt | dsIrq);
      d.g2Oe = 1'b1;
    end
    else
    begin
      d.g2 = outputDriveLevel[1];
      d.g2Oe = outputDriveEnable[1];
    end
    if (outputThreeFunction == 2'h1)
    begin
      d.g3 = 1'b0;
      d.g3Oe = 1'b0;
    end
    else if (outputThreeFunction == 2'h2 && q.dig)
    begin
      d.g3 = audioBitClock;
      d.g3Oe = 1'b1;
    end
    else
    begin
      d.g3 = outputDriveLevel[2];
      d.g3Oe = outputDriveEnable[2];
    end

    // Synchronous reset to defaults; port held idle meanwhile
    if (!reset_n)
    begin
      d = '0;
      d.senS = 2'b11;
      d.cts = 1'b1;
      for (int i = 0; i < 15; i++)
        d.props[i] = propDef(4'(i));
    end
  end

  // Single state register
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  assign sdioOut = q.sdOut;
  assign sdioOe = q.sdOe;
  assign generalOutputOne = q.g1;
  assign generalOutputOneOe = q.g1Oe;
  assign generalOutputTwoIrq = q.g2;
  assign generalOutputTwoIrqOe = q.g2Oe;
  assign generalOutputThree = q.g3;
  assign generalOutputThreeOe = q.g3Oe;
  assign analogEnable = q.pwr;
  assign digitalAudioEnable = q.dig;
  assign crystalEnable = q.xtal;
  assign tunedFrequency = q.freq;
  assign deemphasisSelect = q.props[`I_DEEMPH];
  assign stereoBlendLevel = q.props[`I_STEREO];
  assign monoBlendLevel = q.props[`I_MONO];
  assign softMuteCeiling = q.props[`I_SMUTE];
  assign volumeLevel = q.props[`I_VOL];
  assign muteControl = q.props[`I_MUTE];
  assign dataServiceSetup = q.props[`I_DSCFG];

endmodule : rcpe_core

// [rcpe_core_properties.sv]
`timescale 1ns/100ps
module rcpe_core_properties
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serialEnable_n,
  input wire logic sdioOe,
  input wire logic [2:0] outputDriveEnable,
  input wire logic [2:0] outputDriveLevel,
  input wire logic irqOnOutputTwo,
  input wire logic [1:0] outputThreeFunction,
  input wire logic generalOutputOne,
  input wire logic generalOutputOneOe,
  input wire logic generalOutputTwoIrq,
  input wire logic generalOutputTwoIrqOe,
  input wire logic generalOutputThree,
  input wire logic generalOutputThreeOe,
  input wire logic analogEnable,
  input wire logic [15:0] volumeLevel,
  input wire logic [15:0] deemphasisSelect
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Pin one follows its settings once no read can be routed to it
  a_gpo_one_drive: assert property (serialEnable_n [*6] ##0 $past(reset_n) |->
    generalOutputOneOe == $past(outputDriveEnable[0]) && (!generalOutputOneOe || generalOutputOne == $past(outputDriveLevel[0])))
    else $error("pin one does not follow its drive settings");
  a_gpo_three_drive: assert property ($past(reset_n) && $past(outputThreeFunction) == 2'h0 |->
    generalOutputThreeOe == $past(outputDriveEnable[2]) && (!generalOutputThreeOe || generalOutputThree == $past(outputDriveLevel[2])))
    else $error("pin three does not follow its drive settings");
  a_irq_pin_driven: assert property ($past(reset_n) && $past(irqOnOutputTwo) |-> generalOutputTwoIrqOe)
    else $error("interrupt pin not driven");
  a_crystal_release: assert property ($past(reset_n) && $past(outputThreeFunction) == 2'h1 |-> !generalOutputThreeOe)
    else $error("pin three driven in crystal mode");
  // Reset checks must run while reset is low, so no disable here
  a_reset_defaults: assert property (disable iff (1'b0) !reset_n |=>
    volumeLevel == 16'h003f && deemphasisSelect == 16'h0002 && !analogEnable)
    else $error("settings not at defaults in reset");
  a_bus_quiet_reset: assert property (disable iff (1'b0) !reset_n |=> !sdioOe)
    else $error("data line driven in reset");
  a_sdio_release: assert property (serialEnable_n [*6] |-> !sdioOe)
    else $error("data line driven outside a session");
  // Long margin: execution of the prior write ends well before this
  a_volume_stable: assert property (!serialEnable_n [*8] |-> $stable(volumeLevel))
    else $error("setting changed in mid session");
  c_power_up: cover property ($rose(analogEnable));
  c_read_out: cover property ($rose(sdioOe));
  c_irq_pin: cover property (irqOnOutputTwo && $fell(generalOutputTwoIrq));
endmodule : rcpe_core_properties

bind rcpe_core rcpe_core_properties u_props (.clk(clk), .reset_n(reset_n), .serialEnable_n(serialEnable_n),
  .sdioOe(sdioOe), .outputDriveEnable(outputDriveEnable), .outputDriveLevel(outputDriveLevel),
  .irqOnOutputTwo(irqOnOutputTwo), .outputThreeFunction(outputThreeFunction),
  .generalOutputOne(generalOutputOne), .generalOutputOneOe(generalOutputOneOe),
  .generalOutputTwoIrq(generalOutputTwoIrq), .generalOutputTwoIrqOe(generalOutputTwoIrqOe),
  .generalOutputThree(generalOutputThree), .generalOutputThreeOe(generalOutputThreeOe),
  .analogEnable(analogEnable), .volumeLevel(volumeLevel), .deemphasisSelect(deemphasisSelect));

// [rcpe_host_model.sv]
`timescale 1ns/100ps
`include "rcpe_map.svh"
module rcpe_host_model
(
  input wire logic clk,
  output logic sclkPin,
  output logic serialEnable_n,
  output logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  // Idle: clock stands low, session closed
  initial
  begin
    sclkPin = 1'b0;
    serialEnable_n = 1'b1;
    sdioIn = 1'b1;
  end
  // Half of the 800 ns link period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  // Read bit taken late in the high phase, clear of sync latency
  task automatic tick(input logic d, output logic q);
    sdioIn = d;
    half();
    sclkPin = 1'b1;
    half();
    q = sdioOe ? sdioOut : ~sdioOut; // Released line reads as the inverse
    sclkPin = 1'b0;
  endtask : tick
  // Session: control byte, nb written bits, nr read bits
  task automatic frame(input logic [7:0] ctl, input logic [63:0] d, input int nb, input int nr,
                       output logic [127:0] r);
    logic q;
    r = '0;
    serialEnable_n = 1'b0;
    half();
    for (int i = 7; i >= 0; i--)
      tick(ctl[i], q);
    for (int i = 63; i >= 64 - nb; i--)
      tick(d[i], q);
    for (int i = 0; i < nr; i++)
    begin
      tick(~sdioIn, q);
      r = {r[126:0], q};
    end
    sdioIn = ~sdioIn;
    half();
    serialEnable_n = 1'b1;
    if (nb > 0 && nb < 64)
      tick(~sdioIn, q);
    repeat (4) @(negedge clk);
  endtask : frame
  // Status polled until clear-to-send, bounded
  task automatic poll(output logic ok);
    logic [127:0] s;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++)
    begin
      frame(`K_RD1, 64'h0, 0, 8, s);
      ok = (s[7] === 1'b1);
    end
  endtask : poll
  // Whole command: code plus seven arguments, then sixteen reply bytes
  task automatic cmd(input logic [63:0] d, output logic [127:0] r, output logic ok);
    logic ok1;
    poll(ok1);
    frame(`K_WR, d, 64, 0, r);
    poll(ok);
    ok = ok & ok1;
    frame(`K_RD16, 64'h0, 0, 128, r);
  endtask : cmd
endmodule : rcpe_host_model

// [rcpe_map.svh]
`ifndef RCPE_MAP_SVH
`define RCPE_MAP_SVH
// Command codes
`define C_PWRUP 8'h01
`define C_REV 8'h10
`define C_PWRDN 8'h11
`define C_SETP 8'h12
`define C_GETP 8'h13
`define C_TUNE 8'h20
`define C_SEEK 8'h21
`define C_TSTAT 8'h22
`define C_QSTAT 8'h23
`define C_DSTAT 8'h24
// Serial control bytes
`define K_WR 8'h48
`define K_RD1 8'h80
`define K_RD16 8'hc0
`define K_RD1G 8'ha0
`define K_RD16G 8'he0
// Frame lengths in bits
`define W_BITS 8'h40
`define R_BITS1 8'h08
`define R_BITS16 8'h80
// Property numbers
`define P_DEEMPH 16'h1100
`define P_STEREO 16'h1105
`define P_MONO 16'h1106
`define P_QSEL 16'h1200
`define P_SMUTE 16'h1302
`define P_LOWER 16'h1400
`define P_UPPER 16'h1401
`define P_STEP 16'h1402
`define P_SNR 16'h1403
`define P_RSSI 16'h1404
`define P_DSSEL 16'h1500
`define P_DSTHR 16'h1501
`define P_DSCFG 16'h1502
`define P_VOL 16'h4000
`define P_MUTE 16'h4001
// Property table slots
`define I_DEEMPH 4'h0
`define I_STEREO 4'h1
`define I_MONO 4'h2
`define I_QSEL 4'h3
`define I_SMUTE 4'h4
`define I_LOWER 4'h5
`define I_UPPER 4'h6
`define I_STEP 4'h7
`define I_SNR 4'h8
`define I_RSSI 4'h9
`define I_DSSEL 4'ha
`define I_DSTHR 4'hb
`define I_DSCFG 4'hc
`define I_VOL 4'hd
`define I_MUTE 4'he
`define I_NONE 4'hf
// Property defaults
`define D_DEEMPH 16'h0002
`define D_STEREO 16'h0031
`define D_MONO 16'h001e
`define D_QSEL 16'h0000
`define D_SMUTE 16'h0010
`define D_LOWER 16'h222e
`define D_UPPER 16'h2a26
`define D_STEP 16'h000a
`define D_SNR 16'h0003
`define D_RSSI 16'h0014
`define D_DSSEL 16'h0000
`define D_DSTHR 16'h0000
`define D_DSCFG 16'h0000
`define D_VOL 16'h003f
`define D_MUTE 16'h0000
// Argument bit positions
`define A_XTAL 4
`define A_DIG 0
`define A_UP 3
`define A_WRAP 2
`define A_ACK 0
`endif

// [rcpe_pkg.sv]
package rcpe_pkg;
`include "rcpe_map.svh"
typedef enum logic [2:0] {SER_IDLE, SER_CTRL, SER_WRITE, SER_READ, SER_HOLD} rcpe_ser_t;
typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_SEEK} rcpe_exec_t;
endpackage : rcpe_pkg
